// file: include/albe_map.svh
`ifndef ALBE_MAP_SVH
`define ALBE_MAP_SVH
// flag register bit positions
`define ALBE_FLG_C 0
`define ALBE_FLG_Z 1
`define ALBE_FLG_N 2
`define ALBE_FLG_V 3
`define ALBE_FLG_S 4
`define ALBE_FLG_H 5
`define ALBE_FLG_T 6
`define ALBE_FLG_I 7
`define ALBE_FLG_RESET 8'h00
// pointer low half width, upper pc bits above it
`define ALBE_PC_LOW_W 16
// cycle counts
`define ALBE_CYC_ONE 3'h1
`define ALBE_CYC_PAIR 3'h2
`define ALBE_CYC_MUL 3'h2
`define ALBE_CYC_JUMP 3'h2
`define ALBE_CYC_FAR_CALL 3'h4
`define ALBE_CYC_BRANCH_TAKEN 3'h2
`define ALBE_CYC_SKIP_ONE 3'h2
`define ALBE_CYC_SKIP_TWO 3'h3
// pc steps
`define ALBE_SKIP_ONE_WORD 3'h2
`define ALBE_SKIP_TWO_WORD 3'h3
`define ALBE_BRANCH_STEP 3'h1
`define ALBE_RET_STEP 3'h1
`endif

// file: include/albe_pkg.sv
package albe_pkg;
  typedef enum logic [5:0] {
    albe_op_sum,
    albe_op_sum_carry,
    albe_op_difference,
    albe_op_difference_with_borrow,
    albe_op_flag_compare,
    albe_op_flag_compare_borrow,
    albe_op_pair_immediate_sum,
    albe_op_pair_immediate_difference,
    albe_op_conjunction,
    albe_op_disjunction,
    albe_op_exclusive_disjunction,
    albe_op_mask_set_bits,
    albe_op_mask_clear_bits,
    albe_op_zero_sign_test,
    albe_op_product_unsigned,
    albe_op_product_signed,
    albe_op_product_signed_unsigned,
    albe_op_fraction_product_unsigned,
    albe_op_fraction_product_signed,
    albe_op_fraction_product_mixed,
    albe_op_pointer_jump,
    albe_op_far_pointer_jump,
    albe_op_pointer_call,
    albe_op_far_pointer_call,
    albe_op_equal_skip,
    albe_op_skip_reg_bit_clear,
    albe_op_skip_reg_bit_set,
    albe_op_skip_io_bit_clear,
    albe_op_skip_io_bit_set,
    albe_op_branch_flag_set,
    albe_op_branch_flag_clear,
    albe_op_branch_equal,
    albe_op_branch_not_equal,
    albe_op_branch_carry_set,
    albe_op_branch_carry_clear,
    albe_op_branch_same_higher,
    albe_op_branch_lower,
    albe_op_branch_minus,
    albe_op_branch_plus,
    albe_op_branch_signed_ge,
    albe_op_branch_signed_lt,
    albe_op_branch_half_carry_set,
    albe_op_branch_half_carry_clear,
    albe_op_branch_transfer_bit_set,
    albe_op_branch_transfer_bit_clear,
    albe_op_branch_overflow_set,
    albe_op_branch_overflow_clear,
    albe_op_branch_irq_enabled,
    albe_op_branch_irq_disabled
  } albe_op_t;
endpackage

// file: rtl/albe_exec.sv
`timescale 1ns/1ps
`include "albe_map.svh"
// What this block does
// [RULE_01] byte add/subtract, all six flags, one cycle
// [RULE_02] pair add/subtract immediate, no half-carry, two cycles
// [RULE_03] and/or/xor: Z N V S only, one cycle
// [RULE_04] mask set ors, mask clear ands inverse
// [RULE_05] test ands register with itself, no write
// [RULE_06] 8x8 product into fixed pair, Z C, two cycles
// [RULE_07] fractional products shifted left one bit
// [RULE_08] pointer jump, upper pc cleared, two cycles
// [RULE_09] far jump takes upper bits from extension
// [RULE_10] pointer call, upper cleared, three/four cycles
// [RULE_11] far call uses extension, four cycles
// [RULE_12] equal skip advances pc by two/three
// [RULE_13] register bit skips on clear or set
// [RULE_14] io bit skips on set or clear
// [RULE_15] generic flag branch to pc plus k plus one
// [RULE_16] equal/carry/minus branches test Z C N
// [RULE_17] same-higher on carry 0, lower on 1
// [RULE_18] signed ge/lt test N xor V
// [RULE_19] half-carry branches test H
// [RULE_20] transfer-bit branches test T
// [RULE_21] overflow branches test V
// [RULE_22] irq branches test global enable I
// [RULE_23] compares set all six flags, no write
module albe_exec #(
  parameter int PC_W = 22,
  parameter logic [2:0] CALL_CYCLES = 3'h3
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire albe_pkg::albe_op_t req_op,
  input wire logic src_imm,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] imm_val,
  input wire logic [15:0] pair_val,
  input wire logic [15:0] z_ptr,
  input wire logic [5:0] jump_extension_register,
  input wire logic [PC_W-1:0] pc_val,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] io_val,
  input wire logic next_two_word,
  input wire logic [6:0] branch_offset,
  input wire logic flag_wr,
  input wire logic [7:0] flag_wdata,
  output logic [7:0] flag_register,
  output logic done,
  output logic byte_wr_en,
  output logic [7:0] byte_wr_data,
  output logic pair_wr_en,
  output logic pair_to_product,
  output logic [15:0] pair_wr_data,
  output logic pc_load,
  output logic [PC_W-1:0] pc_target,
  output logic push_en,
  output logic [PC_W-1:0] ret_addr
);

  initial begin
    if (PC_W <= `ALBE_PC_LOW_W || PC_W > `ALBE_PC_LOW_W + 6)
      $error("albe_exec: PC_W must be 17 to 22");
    if (CALL_CYCLES != 3'h3 && CALL_CYCLES != 3'h4)
      $error("albe_exec: CALL_CYCLES must be 3 or 4");
  end

  // returns {h, c, v, result}
  function automatic logic [10:0] arith8(input logic [7:0] a,
      input logic [7:0] b, input logic cin, input logic sub);
    logic [7:0] bb;
    logic ci;
    logic [8:0] s;
    logic [4:0] hs;
    logic v;
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    hs = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    v = (a[7] == bb[7]) && (s[7] != a[7]);
    arith8 = {hs[4] ^ sub, s[8] ^ sub, v, s[7:0]};
  endfunction

  // branch decode: {wanted value, flag index, use N xor V}
  function automatic logic [4:0] br_decode(input albe_pkg::albe_op_t op,
      input logic [2:0] s);
    unique case (op)
      albe_pkg::albe_op_branch_flag_set: br_decode = {1'b1, s, 1'b0};
      albe_pkg::albe_op_branch_flag_clear: br_decode = {1'b0, s, 1'b0};
      albe_pkg::albe_op_branch_equal:
        br_decode = {1'b1, 3'(`ALBE_FLG_Z), 1'b0}; // [RULE_16]
      albe_pkg::albe_op_branch_not_equal:
        br_decode = {1'b0, 3'(`ALBE_FLG_Z), 1'b0};
      albe_pkg::albe_op_branch_carry_set,
      albe_pkg::albe_op_branch_lower:
        br_decode = {1'b1, 3'(`ALBE_FLG_C), 1'b0};
      albe_pkg::albe_op_branch_carry_clear,
      albe_pkg::albe_op_branch_same_higher:
        br_decode = {1'b0, 3'(`ALBE_FLG_C), 1'b0}; // [RULE_17]
      albe_pkg::albe_op_branch_minus:
        br_decode = {1'b1, 3'(`ALBE_FLG_N), 1'b0};
      albe_pkg::albe_op_branch_plus:
        br_decode = {1'b0, 3'(`ALBE_FLG_N), 1'b0};
      albe_pkg::albe_op_branch_signed_ge: br_decode = {1'b0, 3'h0, 1'b1};
      albe_pkg::albe_op_branch_signed_lt: br_decode = {1'b1, 3'h0, 1'b1};
      albe_pkg::albe_op_branch_half_carry_set:
        br_decode = {1'b1, 3'(`ALBE_FLG_H), 1'b0}; // [RULE_19]
      albe_pkg::albe_op_branch_half_carry_clear:
        br_decode = {1'b0, 3'(`ALBE_FLG_H), 1'b0};
      albe_pkg::albe_op_branch_transfer_bit_set:
        br_decode = {1'b1, 3'(`ALBE_FLG_T), 1'b0}; // [RULE_20]
      albe_pkg::albe_op_branch_transfer_bit_clear:
        br_decode = {1'b0, 3'(`ALBE_FLG_T), 1'b0};
      albe_pkg::albe_op_branch_overflow_set:
        br_decode = {1'b1, 3'(`ALBE_FLG_V), 1'b0}; // [RULE_21]
      albe_pkg::albe_op_branch_overflow_clear:
        br_decode = {1'b0, 3'(`ALBE_FLG_V), 1'b0};
      albe_pkg::albe_op_branch_irq_enabled:
        br_decode = {1'b1, 3'(`ALBE_FLG_I), 1'b0}; // [RULE_22]
      albe_pkg::albe_op_branch_irq_disabled:
        br_decode = {1'b0, 3'(`ALBE_FLG_I), 1'b0};
      default: br_decode = 5'h00;
    endcase
  endfunction

  logic busy_reg;
  logic [2:0] cnt_reg;
  logic [7:0] flag_reg;
  logic w8_reg;
  logic [7:0] d8_reg;
  logic w16_reg;
  logic fixed_reg;
  logic [15:0] d16_reg;
  logic pcl_reg;
  logic [PC_W-1:0] tgt_reg;
  logic push_reg;
  logic [PC_W-1:0] ret_reg;

  logic accept;
  logic [7:0] src;
  logic [7:0] flag_next;
  logic w8_next;
  logic [7:0] d8_next;
  logic w16_next;
  logic fixed_next;
  logic [15:0] d16_next;
  logic pcl_next;
  logic [PC_W-1:0] tgt_next;
  logic push_next;
  logic [2:0] cyc_next;
  logic [10:0] ar;
  logic [16:0] pr;
  logic [17:0] prod;
  logic [15:0] pres;
  logic [4:0] brd;
  logic cond;
  logic [PC_W-1:0] skip_step;
  logic [PC_W-1:0] far_hi;

  // a new request may follow in the cycle that finishes the last one
  assign req_ready = !busy_reg || (cnt_reg == `ALBE_CYC_ONE - 3'h1);
  assign accept = req_valid && req_ready;
  assign done = busy_reg && (cnt_reg == `ALBE_CYC_ONE - 3'h1);
  assign flag_register = flag_reg;
  assign byte_wr_en = done && w8_reg;
  assign byte_wr_data = d8_reg;
  assign pair_wr_en = done && w16_reg;
  assign pair_to_product = fixed_reg;
  assign pair_wr_data = d16_reg;
  assign pc_load = done && pcl_reg;
  assign pc_target = tgt_reg;
  assign push_en = done && push_reg;
  assign ret_addr = ret_reg;

  always_comb begin
    src = src_imm ? imm_val : rr_val;
    flag_next = flag_reg;
    w8_next = 1'b0;
    d8_next = 8'h00;
    w16_next = 1'b0;
    fixed_next = 1'b0;
    d16_next = 16'h0000;
    pcl_next = 1'b0;
    tgt_next = pc_val;
    push_next = 1'b0;
    cyc_next = `ALBE_CYC_ONE;
    ar = 11'h000;
    pr = 17'h00000;
    prod = 18'h00000;
    pres = 16'h0000;
    brd = br_decode(req_op, bit_sel);
    cond = 1'b0;
    skip_step = next_two_word ? PC_W'(`ALBE_SKIP_TWO_WORD)
                              : PC_W'(`ALBE_SKIP_ONE_WORD);
    far_hi = {jump_extension_register[PC_W-`ALBE_PC_LOW_W-1:0],
              16'h0000};
    unique case (req_op)
      albe_pkg::albe_op_sum, albe_pkg::albe_op_sum_carry,
      albe_pkg::albe_op_difference,
      albe_pkg::albe_op_difference_with_borrow,
      albe_pkg::albe_op_flag_compare,
      albe_pkg::albe_op_flag_compare_borrow: begin
        ar = arith8(rd_val, src,
          flag_reg[`ALBE_FLG_C] &&
          (req_op == albe_pkg::albe_op_sum_carry ||
           req_op == albe_pkg::albe_op_difference_with_borrow ||
           req_op == albe_pkg::albe_op_flag_compare_borrow),
          req_op != albe_pkg::albe_op_sum &&
          req_op != albe_pkg::albe_op_sum_carry); // [RULE_01] [RULE_23]
        d8_next = ar[7:0];
        // compares keep the destination untouched
        w8_next = req_op != albe_pkg::albe_op_flag_compare &&
                  req_op != albe_pkg::albe_op_flag_compare_borrow; // [RULE_23]
        flag_next[`ALBE_FLG_H] = ar[10];
        flag_next[`ALBE_FLG_C] = ar[9];
        flag_next[`ALBE_FLG_V] = ar[8];
        flag_next[`ALBE_FLG_N] = ar[7];
        flag_next[`ALBE_FLG_S] = ar[7] ^ ar[8];
        flag_next[`ALBE_FLG_Z] = ar[7:0] == 8'h00; // [RULE_01]
      end
      albe_pkg::albe_op_pair_immediate_sum,
      albe_pkg::albe_op_pair_immediate_difference: begin
        if (req_op == albe_pkg::albe_op_pair_immediate_sum) begin
          pr = {1'b0, pair_val} + {11'h000, imm_val[5:0]};
          flag_next[`ALBE_FLG_V] = !pair_val[15] && pr[15];
        end else begin
          pr = {1'b0, pair_val} - {11'h000, imm_val[5:0]};
          flag_next[`ALBE_FLG_V] = pair_val[15] && !pr[15];
        end
        w16_next = 1'b1;
        d16_next = pr[15:0];
        flag_next[`ALBE_FLG_C] = pr[16];
        flag_next[`ALBE_FLG_N] = pr[15];
        flag_next[`ALBE_FLG_S] = pr[15] ^ flag_next[`ALBE_FLG_V];
        flag_next[`ALBE_FLG_Z] = pr[15:0] == 16'h0000;
        cyc_next = `ALBE_CYC_PAIR; // [RULE_02]
      end
      albe_pkg::albe_op_conjunction, albe_pkg::albe_op_disjunction,
      albe_pkg::albe_op_exclusive_disjunction,
      albe_pkg::albe_op_mask_set_bits, albe_pkg::albe_op_mask_clear_bits,
      albe_pkg::albe_op_zero_sign_test: begin
        unique case (req_op)
          albe_pkg::albe_op_conjunction: d8_next = rd_val & src; // [RULE_03]
          albe_pkg::albe_op_disjunction: d8_next = rd_val | src;
          albe_pkg::albe_op_exclusive_disjunction: d8_next = rd_val ^ src;
          albe_pkg::albe_op_mask_set_bits:
            d8_next = rd_val | imm_val; // [RULE_04]
          albe_pkg::albe_op_mask_clear_bits:
            d8_next = rd_val & ~imm_val; // [RULE_04]
          default: d8_next = rd_val & rd_val; // [RULE_05]
        endcase
        // the test only looks, so no write-back
        w8_next = req_op != albe_pkg::albe_op_zero_sign_test; // [RULE_05]
        flag_next[`ALBE_FLG_V] = 1'b0;
        flag_next[`ALBE_FLG_N] = d8_next[7];
        flag_next[`ALBE_FLG_S] = d8_next[7];
        flag_next[`ALBE_FLG_Z] = d8_next == 8'h00; // [RULE_03]
      end
      albe_pkg::albe_op_product_unsigned, albe_pkg::albe_op_product_signed,
      albe_pkg::albe_op_product_signed_unsigned,
      albe_pkg::albe_op_fraction_product_unsigned,
      albe_pkg::albe_op_fraction_product_signed,
      albe_pkg::albe_op_fraction_product_mixed: begin
        prod = $signed({rd_val[7] &&
          req_op != albe_pkg::albe_op_product_unsigned &&
          req_op != albe_pkg::albe_op_fraction_product_unsigned, rd_val}) *
          $signed({rr_val[7] &&
          (req_op == albe_pkg::albe_op_product_signed ||
           req_op == albe_pkg::albe_op_fraction_product_signed), rr_val});
        // carry is the product msb before the fractional shift
        flag_next[`ALBE_FLG_C] = prod[15]; // [RULE_06]
        if (req_op == albe_pkg::albe_op_fraction_product_unsigned ||
            req_op == albe_pkg::albe_op_fraction_product_signed ||
            req_op == albe_pkg::albe_op_fraction_product_mixed) begin
          pres = {prod[14:0], 1'b0}; // [RULE_07]
        end else begin
          pres = prod[15:0]; // [RULE_06]
        end
        flag_next[`ALBE_FLG_Z] = pres == 16'h0000;
        w16_next = 1'b1;
        fixed_next = 1'b1;
        d16_next = pres;
        cyc_next = `ALBE_CYC_MUL; // [RULE_06] [RULE_07]
      end
      albe_pkg::albe_op_pointer_jump: begin
        pcl_next = 1'b1;
        tgt_next = PC_W'(z_ptr); // [RULE_08]
        cyc_next = `ALBE_CYC_JUMP;
      end
      albe_pkg::albe_op_far_pointer_jump: begin
        pcl_next = 1'b1;
        tgt_next = far_hi | PC_W'(z_ptr); // [RULE_09]
        cyc_next = `ALBE_CYC_JUMP;
      end
      albe_pkg::albe_op_pointer_call: begin
        pcl_next = 1'b1;
        push_next = 1'b1;
        tgt_next = PC_W'(z_ptr); // [RULE_10]
        cyc_next = CALL_CYCLES; // [RULE_10]
      end
      albe_pkg::albe_op_far_pointer_call: begin
        pcl_next = 1'b1;
        push_next = 1'b1;
        tgt_next = far_hi | PC_W'(z_ptr); // [RULE_11]
        cyc_next = `ALBE_CYC_FAR_CALL; // [RULE_11]
      end
      albe_pkg::albe_op_equal_skip, albe_pkg::albe_op_skip_reg_bit_clear,
      albe_pkg::albe_op_skip_reg_bit_set,
      albe_pkg::albe_op_skip_io_bit_clear,
      albe_pkg::albe_op_skip_io_bit_set: begin
        unique case (req_op)
          albe_pkg::albe_op_equal_skip: cond = rd_val == rr_val; // [RULE_12]
          albe_pkg::albe_op_skip_reg_bit_clear:
            cond = !rr_val[bit_sel]; // [RULE_13]
          albe_pkg::albe_op_skip_reg_bit_set: cond = rr_val[bit_sel];
          albe_pkg::albe_op_skip_io_bit_clear:
            cond = !io_val[bit_sel]; // [RULE_14]
          default: cond = io_val[bit_sel]; // [RULE_14]
        endcase
        if (cond) begin
          pcl_next = 1'b1;
          tgt_next = pc_val + skip_step; // [RULE_12]
          cyc_next = next_two_word ? `ALBE_CYC_SKIP_TWO
                                   : `ALBE_CYC_SKIP_ONE; // [RULE_12]
        end
      end
      default: begin
        // every remaining code is a conditional branch
        cond = (brd[0] ? (flag_reg[`ALBE_FLG_N] ^ flag_reg[`ALBE_FLG_V])
                       : flag_reg[brd[3:1]]) == brd[4]; // [RULE_15] [RULE_18]
        if (cond) begin
          pcl_next = 1'b1;
          tgt_next = pc_val + {{(PC_W-7){branch_offset[6]}}, branch_offset}
                     + PC_W'(`ALBE_BRANCH_STEP); // [RULE_15]
          cyc_next = `ALBE_CYC_BRANCH_TAKEN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      cnt_reg <= 3'h0;
    end else if (accept) begin
      busy_reg <= 1'b1;
      cnt_reg <= cyc_next - 3'h1;
    end else if (done) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  // flags move at acceptance so a following branch sees them at once
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= `ALBE_FLG_RESET;
    end else if (accept) begin
      flag_reg <= flag_next;
    end else if (flag_wr) begin
      flag_reg <= flag_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      w8_reg <= 1'b0;
      d8_reg <= 8'h00;
      w16_reg <= 1'b0;
      fixed_reg <= 1'b0;
      d16_reg <= 16'h0000;
      pcl_reg <= 1'b0;
      tgt_reg <= '0;
      push_reg <= 1'b0;
      ret_reg <= '0;
    end else if (accept) begin
      w8_reg <= w8_next;
      d8_reg <= d8_next;
      w16_reg <= w16_next;
      fixed_reg <= fixed_next;
      d16_reg <= d16_next;
      pcl_reg <= pcl_next;
      tgt_reg <= tgt_next;
      push_reg <= push_next;
      ret_reg <= pc_val + PC_W'(`ALBE_RET_STEP);
    end
  end

endmodule

// file: test/albe_exec_sva.sv
`timescale 1ns/1ps
`include "albe_map.svh"
module albe_exec_sva (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire albe_pkg::albe_op_t req_op,
  input wire logic [7:0] flag_register,
  input wire logic done,
  input wire logic byte_wr_en,
  input wire logic pair_wr_en,
  input wire logic pair_to_product,
  input wire logic pc_load,
  input wire logic push_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic acc;
  assign acc = req_valid && req_ready;
  chk_byte_one_cycle: assert property (
    acc && req_op == albe_pkg::albe_op_sum |=> done && byte_wr_en)
    else $error("byte op late");
  chk_pair_two_cycle: assert property (
    acc && req_op inside {albe_pkg::albe_op_pair_immediate_sum,
    albe_pkg::albe_op_pair_immediate_difference}
    |=> !done ##1 done && pair_wr_en && !pair_to_product)
    else $error("pair op timing");
  chk_pair_keeps_half: assert property (
    acc && req_op inside {albe_pkg::albe_op_pair_immediate_sum,
    albe_pkg::albe_op_pair_immediate_difference}
    |=> $stable(flag_register[`ALBE_FLG_H]))
    else $error("pair op touched half carry");
  chk_logic_keeps_carry: assert property (
    acc && req_op inside {[albe_pkg::albe_op_conjunction :
    albe_pkg::albe_op_zero_sign_test]} |=> done &&
    $stable(flag_register[`ALBE_FLG_C]) && $stable(flag_register[`ALBE_FLG_H]))
    else $error("logic op touched carry");
  chk_test_no_write: assert property (
    acc && req_op inside {albe_pkg::albe_op_zero_sign_test,
    albe_pkg::albe_op_flag_compare, albe_pkg::albe_op_flag_compare_borrow}
    |=> done && !byte_wr_en)
    else $error("test or compare wrote back");
  chk_product_fixed_pair: assert property (
    acc && req_op inside {[albe_pkg::albe_op_product_unsigned :
    albe_pkg::albe_op_fraction_product_mixed]}
    |=> !done ##1 done && pair_wr_en && pair_to_product)
    else $error("product timing or target");
  chk_jump_two_cycle: assert property (
    acc && req_op inside {albe_pkg::albe_op_pointer_jump,
    albe_pkg::albe_op_far_pointer_jump}
    |=> !done ##1 done && pc_load && !push_en)
    else $error("jump timing");
  chk_far_call_four: assert property (
    acc && req_op == albe_pkg::albe_op_far_pointer_call
    |=> !done [*3] ##1 done && pc_load && push_en)
    else $error("far call timing");
  chk_flow_keeps_flags: assert property (
    acc && req_op inside {[albe_pkg::albe_op_pointer_jump :
    albe_pkg::albe_op_branch_irq_disabled]} |=> $stable(flag_register))
    else $error("flow op changed flags");
  cover property (acc && req_op == albe_pkg::albe_op_far_pointer_call);
  cover property (done && pc_load && !push_en);
  cover property (acc && req_op == albe_pkg::albe_op_product_signed);
endmodule

// file: test/albe_fetch_model.sv
`timescale 1ns/1ps
module albe_fetch_model #(
  parameter int PC_W = 22
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic done,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_target,
  output logic [PC_W-1:0] pc_val
);
  // untaken flow steps one word only; two-word fetch is not modelled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc_val <= PC_W'(12'h100);
    end else if (done && pc_load) begin
      pc_val <= pc_target;
    end else if (done) begin
      pc_val <= pc_val + PC_W'(1'h1);
    end
  end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic src_imm = 1'b0;
  logic next_two_word = 1'b0;
  logic flag_wr = 1'b0;
  albe_pkg::albe_op_t req_op = albe_pkg::albe_op_sum;
  logic [7:0] rd_val = 8'h00, rr_val = 8'h00, imm_val = 8'h00;
  logic [7:0] io_val = 8'h00, flag_wdata = 8'h00;
  logic [15:0] pair_val = 16'h0000, z_ptr = 16'h0000;
  logic [5:0] jump_extension_register = 6'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [6:0] branch_offset = 7'h00;
  logic [21:0] pc_val, pc_target, ret_addr, pc_at;
  logic req_ready, done, byte_wr_en, pair_wr_en, pair_to_product;
  logic pc_load, push_en;
  logic [7:0] flag_register, byte_wr_data;
  logic [15:0] pair_wr_data;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  always #4 clk_sys = ~clk_sys;
  albe_exec #(.PC_W(22), .CALL_CYCLES(3'h3)) u_dut (.*);
  albe_fetch_model #(.PC_W(22)) u_fe (.*);
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      $display("[FAIL] t=%0t run hung", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] t=%0t %s", $time, msg);
    end
  endtask
  // returns in the done cycle, so comb pulses are still visible
  task automatic run_op(input albe_pkg::albe_op_t op);
    @(posedge clk_sys);
    #1;
    req_op = op;
    req_valid = 1'b1;
    pc_at = pc_val;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic set_flags(input logic [7:0] v);
    @(posedge clk_sys);
    #1;
    flag_wr = 1'b1;
    flag_wdata = v;
    @(posedge clk_sys);
    #1;
    flag_wr = 1'b0;
    chk(flag_register === v, "flag load");
  endtask
  task automatic byte_case(input albe_pkg::albe_op_t op, input logic [7:0] a,
      b, k, input logic si, input logic [7:0] res, ef, input logic wr);
    rd_val = a;
    rr_val = b;
    imm_val = k;
    src_imm = si;
    run_op(op);
    chk(n == 1 && byte_wr_en === wr && (!wr || byte_wr_data === res), "byte");
    chk(flag_register === ef, "byte flags");
  endtask
  task automatic pair_case(input albe_pkg::albe_op_t op, input logic [7:0] a,
      b, input logic [15:0] pv, res, input logic [7:0] ef, input logic pr);
    rd_val = a;
    rr_val = b;
    pair_val = pv;
    imm_val = 8'h01;
    run_op(op);
    chk(n == 2 && pair_wr_en === 1'b1 && pair_to_product === pr, "pair");
    chk(pair_wr_data === res && flag_register === ef, "pair data");
  endtask
  task automatic flow_case(input albe_pkg::albe_op_t op, input int c,
      input logic [21:0] t, input logic call);
    run_op(op);
    chk(n == c && pc_load === 1'b1 && pc_target === t, "flow");
    chk(push_en === call && (!call || ret_addr === pc_at + 22'h1), "call");
  endtask
  // {wanted level, flag index} of the named branches, equal to irq off
  logic [3:0] br_tab [31:48] = '{4'h9, 4'h1, 4'h8, 4'h0, 4'h0, 4'h8, 4'ha,
    4'h2, 4'h0, 4'h8, 4'hd, 4'h5, 4'he, 4'h6, 4'hb, 4'h3, 4'hf, 4'h7};
  function automatic logic br_taken(input int i, input logic [7:0] f,
      input logic [2:0] s);
    logic [3:0] e;
    e = i < 31 ? {i == 29, s} : br_tab[i];
    // signed ge/lt test n xor v
    return (i inside {39, 40} ? f[2] ^ f[3] : f[e[2:0]]) == e[3];
  endfunction
  task automatic test_bytes();
    set_flags(8'h00);
    byte_case(albe_pkg::albe_op_sum, 8'h7f, 8'h01, 8'h00, 1'b0, 8'h80,
      8'h2c, 1'b1);
    byte_case(albe_pkg::albe_op_difference, 8'h10, 8'h00, 8'h20, 1'b1, 8'hf0,
      8'h15, 1'b1);
    byte_case(albe_pkg::albe_op_difference_with_borrow, 8'h10, 8'h0f, 8'h00,
      1'b0, 8'h00, 8'h22, 1'b1);
    byte_case(albe_pkg::albe_op_flag_compare, 8'h05, 8'h06, 8'h00, 1'b0,
      8'h00, 8'h35, 1'b0);
    set_flags(8'h21);
    byte_case(albe_pkg::albe_op_conjunction, 8'hf0, 8'h80, 8'h00, 1'b0, 8'h80,
      8'h35, 1'b1);
    byte_case(albe_pkg::albe_op_exclusive_disjunction, 8'h0f, 8'h0f, 8'h00,
      1'b0, 8'h00, 8'h23, 1'b1);
    byte_case(albe_pkg::albe_op_mask_clear_bits, 8'hff, 8'h00, 8'h0f, 1'b1,
      8'hf0, 8'h35, 1'b1);
    byte_case(albe_pkg::albe_op_mask_set_bits, 8'h00, 8'h00, 8'h81, 1'b1,
      8'h81, 8'h35, 1'b1);
    byte_case(albe_pkg::albe_op_zero_sign_test, 8'h00, 8'h00, 8'h00, 1'b0,
      8'h00, 8'h23, 1'b0);
    $display("byte tests done");
  endtask
  task automatic test_pairs();
    set_flags(8'h20);
    pair_case(albe_pkg::albe_op_pair_immediate_sum, 8'h00, 8'h00, 16'hffff,
      16'h0000, 8'h23, 1'b0);
    pair_case(albe_pkg::albe_op_pair_immediate_difference, 8'h00, 8'h00,
      16'h0000, 16'hffff, 8'h35, 1'b0);
    pair_case(albe_pkg::albe_op_product_unsigned, 8'hff, 8'hff, 16'h0000,
      16'hfe01, 8'h35, 1'b1);
    pair_case(albe_pkg::albe_op_product_signed, 8'hff, 8'h02, 16'h0000,
      16'hfffe, 8'h35, 1'b1);
    pair_case(albe_pkg::albe_op_product_signed_unsigned, 8'hff, 8'h02,
      16'h0000, 16'hfffe, 8'h35, 1'b1);
    pair_case(albe_pkg::albe_op_fraction_product_unsigned, 8'h80, 8'h80,
      16'h0000, 16'h8000, 8'h34, 1'b1);
    pair_case(albe_pkg::albe_op_fraction_product_signed, 8'h80, 8'h80,
      16'h0000, 16'h8000, 8'h34, 1'b1);
    pair_case(albe_pkg::albe_op_fraction_product_mixed, 8'h00, 8'h05,
      16'h0000, 16'h0000, 8'h36, 1'b1);
    $display("pair tests done");
  endtask
  task automatic test_flow();
    z_ptr = 16'h1234;
    jump_extension_register = 6'h2a;
    flow_case(albe_pkg::albe_op_pointer_jump, 2, 22'h001234, 1'b0);
    flow_case(albe_pkg::albe_op_far_pointer_jump, 2, 22'h2a1234,
      1'b0);
    flow_case(albe_pkg::albe_op_pointer_call, 3, 22'h001234, 1'b1);
    flow_case(albe_pkg::albe_op_far_pointer_call, 4, 22'h2a1234,
      1'b1);
    $display("flow tests done");
  endtask
  task automatic test_skips();
    albe_pkg::albe_op_t op;
    logic tk;
    for (int i = 24; i <= 28; i++) begin
      for (int c = 0; c < 2; c++) begin
        op = albe_pkg::albe_op_t'(i);
        rd_val = 8'h5a;
        rr_val = c[0] ? 8'h5a : 8'ha5;
        io_val = rr_val;
        bit_sel = 3'h1;
        next_two_word = c[0];
        // operands equal and bit 1 set exactly when c is 1
        tk = c[0] ^ (op inside {albe_pkg::albe_op_skip_reg_bit_clear,
          albe_pkg::albe_op_skip_io_bit_clear});
        run_op(op);
        chk(tk ? (n == 2 + c && pc_load === 1'b1 && pc_target ===
          pc_at + 22'(2 + c)) : (n == 1 && pc_load === 1'b0),
          "skip");
      end
    end
    $display("skip tests done");
  endtask
  task automatic test_branches();
    logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
    albe_pkg::albe_op_t op;
    logic [21:0] tgt;
    for (int i = 29; i <= 48; i++) begin
      for (int p = 0; p < 4; p++) begin
        set_flags(pats[p]);
        op = albe_pkg::albe_op_t'(i);
        bit_sel = 3'(i + p);
        branch_offset = p[0] ? 7'h05 : 7'h7e;
        run_op(op);
        tgt = pc_at + {{15{branch_offset[6]}}, branch_offset} + 22'h1;
        chk(br_taken(i, pats[p], bit_sel) ? (n == 2 && pc_load === 1'b1 &&
          pc_target === tgt) : (n == 1 && pc_load === 1'b0),
          "branch");
        chk(flag_register === pats[p], "branch flags");
      end
    end
    $display("branch tests done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    chk(req_ready === 1'b1 && done === 1'b0 && flag_register === 8'h00,
      "reset state");
    test_bytes();
    test_pairs();
    test_flow();
    test_skips();
    test_branches();
    report_and_stop();
  end
endmodule
bind albe_exec albe_exec_sva u_sva (.*);
